//--- core/host_port_consts.svh
// Shared constants for the dual host port (pins, register offsets, timing).
// Behaviour
// RULE1 - Select high: serial pins live, parallel-only pins ignored.
// RULE2 - Select low: full parallel bus and strobes active.
// RULE3 - Host holds the select pin fixed throughout.
// RULE4 - Address latch strobe falling edge captures bus address.
// RULE5 - Store strobe writes register; read strobe drives bus.
// RULE6 - Chip select low throughout any parallel strobe.
// RULE7 - Serial use: strobes high, latch strobe, upper lines low.
// RULE8 - Serial transaction spans one chip select low interval.
// RULE9 - Serial address byte first, then data bytes.
// RULE10 - Direction pin high reads, low writes.
// RULE11 - Auto-decrement bit steps address after each byte.
// RULE12 - Serial bytes travel most significant bit first.
// RULE13 - Serial input sampled on serial clock rising edge.
// RULE14 - Output edge select picks rising or falling shift.
// RULE15 - Chip select high releases output, clears counters.
// RULE16 - Both ports share one map; only selected port acts.
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
// Serial pin positions on the multiplexed bus lines.
`define SI_DIN 0
`define SI_DO 1
`define SI_CLK 2
`define SI_WN 3
`define SI_EDGE 4
// Control pin positions in the device's sampled control vector.
`define C_SEL 4
`define C_CS 3
`define C_ALE 2
`define C_RD 1
`define C_WR 0
`define CTL_IDLE 5'h0B
// Bus drive patterns, output enable low means driven.
`define DRIVE_ALL 8'h00
`define RELEASE_ALL 8'hFF
`define DO_ONLY 8'hFD
`define HOST_SI_OE 8'h02
// Device register map.
`define CFG_ADDR 8'h00
`define DECR_BIT 1
`define STAT_ADDR 8'hFF
`define RST_BYTE 8'h00
// Host Wishbone register offsets and fields.
`define WB_CTRL 8'h00
`define WB_ADDR 8'h04
`define WB_COUNT 8'h08
`define WB_TXDATA 8'h0C
`define WB_RXDATA 8'h10
`define WB_STATUS 8'h14
`define CTRL_START 0
`define CTRL_READ 1
`define CTRL_EDGE 2
`define SETTLE_DONE 2'h3
// Timing: least times, rounded up to whole clock cycles.
`define CLK_NS 40
`define PHASE_NS 320
`define SCLK_HALF_NS 240
`define PHASE_CYC ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- core/host_port_pkg.sv
// Types shared by the host end of the dual host port.
package host_port_pkg;
    typedef enum logic [3:0] {
        H_IDLE, H_ALE_HI, H_ALE_LO, H_STB, H_REL, H_CSS, H_LOW, H_HIGH, H_LOAD, H_END
    } host_state_t;
endpackage : host_port_pkg

//--- core/host_port_if.sv
// Pin bundle joining the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
interface host_port_if;
    logic mode_sel;
    logic cs_n;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [7:0] h_q;
    logic [7:0] h_oe_n;
    logic [7:0] d_q;
    logic [7:0] d_oe_n;
    logic [7:0] ad;
    // Resolved bus level; an undriven line floats high through a pull-up.
    assign ad = (~d_oe_n & d_q) | (d_oe_n & ~h_oe_n & h_q) | (d_oe_n & h_oe_n);
    modport dev (input mode_sel, input cs_n, input ale, input rd_n, input wr_n, input ad,
                 output d_q, output d_oe_n);
    modport host (output mode_sel, output cs_n, output ale, output rd_n, output wr_n,
                  output h_q, output h_oe_n, input ad);
endinterface : host_port_if
`default_nettype wire

//--- core/host_port_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module host_port_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("FIFO depth must be a power of two of at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;
    fifo_state_t s_reg, s_next;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_o = s_reg.cnt != (AW + 1)'(DEPTH);
    assign out_valid_o = s_reg.cnt != '0;
    assign out_data_o = s_reg.mem[s_reg.rp];

    // Push and pop may share a cycle; the count then stays put.
    always_comb begin
        s_next = s_reg;
        push = in_valid_i && in_ready_o;
        pop = out_ready_i && out_valid_o;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data_i;
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : host_port_fifo
`default_nettype wire

//--- core/host_port_device.sv
// Device end of the dual host port: parallel and serial slave over one register map.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_consts.svh"
module host_port_device #(
    parameter int NREG = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host pins
    host_port_if.dev pins,
    // Core side
    input wire logic [7:0] status_i,
    output logic serial_mode_o,
    output logic wr_pulse_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    import host_port_pkg::*;

    localparam int IW = $clog2(NREG);
    if (NREG < 2 || NREG > 255) begin : g_bad
        $error("NREG must lie between 2 and 255");
    end

    typedef struct packed {
        logic [7:0] ad1;
        logic [7:0] ad2;
        logic [4:0] c1;
        logic [4:0] c2;
        logic [4:0] cp;
        logic clkp;
        logic [7:0] latch;
        logic [NREG-1:0][7:0] regs;
        logic [7:0] isr;
        logic [7:0] osr;
        logic [2:0] bcnt;
        logic have_addr;
        logic load_pend;
        logic [7:0] dq;
        logic [7:0] doe_n;
        logic ser;
        logic wr_v;
        logic [7:0] wr_a;
        logic [7:0] wr_d;
    } dev_state_t;

    dev_state_t s_reg;
    dev_state_t s_next;
    logic sel;
    logic rise;
    logic fall;
    logic oedge;
    logic decr;
    logic we;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] byte_in;

    // Both ports read through here so they see one and the same map.
    function automatic logic [7:0] read_byte(input logic [NREG-1:0][7:0] r,
                                             input logic [7:0] st,
                                             input logic [7:0] a);
        if (a == `STAT_ADDR) begin
            return st;
        end else if (int'(a) < NREG) begin
            return r[a[IW-1:0]];
        end
        return `RST_BYTE;
    endfunction : read_byte

    // Outputs are plain register copies.
    assign pins.d_q = s_reg.dq;
    assign pins.d_oe_n = s_reg.doe_n;
    assign serial_mode_o = s_reg.ser;
    assign wr_pulse_o = s_reg.wr_v;
    assign wr_addr_o = s_reg.wr_a;
    assign wr_data_o = s_reg.wr_d;

    // Next-state logic. All pins pass two flip-flops (ad1/c1 then ad2/c2)
    // before anything looks at them; cp and clkp hold the previous
    // synchronised level for edge detection.
    always_comb begin
        s_next = s_reg;
        we = 1'b0;
        wa = `RST_BYTE;
        wd = `RST_BYTE;
        byte_in = `RST_BYTE;
        rise = 1'b0;
        fall = 1'b0;
        oedge = 1'b0;
        s_next.ad1 = pins.ad;
        s_next.ad2 = s_reg.ad1;
        s_next.c1 = {pins.mode_sel, pins.cs_n, pins.ale, pins.rd_n, pins.wr_n};
        s_next.c2 = s_reg.c1;
        s_next.cp = s_reg.c2;
        s_next.clkp = s_reg.ad2[`SI_CLK];
        s_next.ser = s_reg.c2[`C_SEL];
        s_next.wr_v = 1'b0;
        sel = !s_reg.c2[`C_CS];
        decr = s_reg.regs[`CFG_ADDR][`DECR_BIT];

        if (!s_reg.c2[`C_SEL]) begin
            // Parallel port; the serial machine is held cleared.
            s_next.bcnt = '0;
            s_next.have_addr = 1'b0;
            s_next.load_pend = 1'b0;
            if (s_reg.cp[`C_ALE] && !s_reg.c2[`C_ALE]) begin
                s_next.latch = s_reg.ad2; // see RULE4, see RULE2
            end
            // The write lands at the store strobe's rising edge, when the
            // data has been stable for the whole low time.
            if (sel && !s_reg.cp[`C_WR] && s_reg.c2[`C_WR]) begin
                we = 1'b1; // see RULE5, see RULE6
                wa = s_reg.latch;
                wd = s_reg.ad2;
            end
            if (sel && !s_reg.c2[`C_RD]) begin
                s_next.doe_n = `DRIVE_ALL; // see RULE5
                s_next.dq = read_byte(s_reg.regs, status_i, s_reg.latch);
            end else begin
                s_next.doe_n = `RELEASE_ALL;
            end
        end else if (!sel) begin
            // Serial port idle: parallel strobes and upper lines are ignored.
            s_next.bcnt = '0; // see RULE15, see RULE1, see RULE8
            s_next.have_addr = 1'b0;
            s_next.load_pend = 1'b0;
            s_next.doe_n = `RELEASE_ALL;
            s_next.dq = `RST_BYTE;
        end else begin
            rise = s_reg.ad2[`SI_CLK] && !s_reg.clkp;
            fall = !s_reg.ad2[`SI_CLK] && s_reg.clkp;
            // Shift-out edge follows the output edge select line.
            oedge = s_reg.ad2[`SI_EDGE] ? fall : rise; // see RULE14

            if (rise) begin
                byte_in = {s_reg.isr[6:0], s_reg.ad2[`SI_DIN]}; // see RULE13, see RULE12
                s_next.isr = byte_in;
                s_next.bcnt = s_reg.bcnt + 1'b1;
                if (s_reg.bcnt == 3'h7) begin
                    s_next.load_pend = 1'b1;
                    if (!s_reg.have_addr) begin
                        s_next.latch = byte_in; // see RULE9
                        s_next.have_addr = 1'b1;
                    end else begin
                        if (!s_reg.ad2[`SI_WN]) begin
                            we = 1'b1; // see RULE10
                            wa = s_reg.latch;
                            wd = byte_in;
                        end
                        if (decr) begin
                            s_next.latch = s_reg.latch - 1'b1; // see RULE11
                        end
                    end
                end
            end

            // A completed byte queues a fresh load; otherwise the output
            // register shifts towards its top bit.
            if (oedge) begin
                if (s_next.load_pend) begin
                    s_next.osr = read_byte(s_reg.regs, status_i, s_next.latch);
                    s_next.load_pend = 1'b0;
                end else begin
                    s_next.osr = {s_reg.osr[6:0], 1'b0}; // see RULE12
                end
            end
            s_next.dq = `RST_BYTE;
            s_next.dq[`SI_DO] = s_next.osr[7];
            // Only a read transaction drives the data output line.
            s_next.doe_n = s_reg.ad2[`SI_WN] ? `DO_ONLY : `RELEASE_ALL; // see RULE10
        end

        // One write path for both ports into the shared map.
        if (we) begin
            if (int'(wa) < NREG) begin
                s_next.regs[wa[IW-1:0]] = wd; // see RULE16
            end
            s_next.wr_v = 1'b1;
            s_next.wr_a = wa;
            s_next.wr_d = wd;
        end
    end

    // State register with idle control pin levels preloaded in the control synchronisers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.c1 <= `CTL_IDLE;
            s_reg.c2 <= `CTL_IDLE;
            s_reg.cp <= `CTL_IDLE;
            s_reg.doe_n <= `RELEASE_ALL;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : host_port_device
`default_nettype wire

//--- core/host_port_host.sv
// Host end of the dual host port: Wishbone-commanded parallel or serial master.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_consts.svh"
module host_port_host #(
    parameter int PHASE = `PHASE_CYC,
    parameter int HALF = `SCLK_HALF_CYC,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port select strap
    input wire logic serial_strap_i,
    // Device pins
    host_port_if.host pins
);
    import host_port_pkg::*;

    if (PHASE < 1 || PHASE > 15 || HALF < 1 || HALF > 15) begin : g_bad
        $error("PHASE and HALF must lie between 1 and 15");
    end

    typedef struct packed {
        logic [7:0] ad1;
        logic [7:0] ad2;
        logic sp1;
        logic sp2;
        logic serial;
        logic [1:0] settle;
        host_state_t st;
        logic [3:0] tmr;
        logic [2:0] bitc;
        logic abyte;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] addr_r;
        logic [7:0] count_r;
        logic [7:0] rxdata;
        logic [7:0] cur;
        logic [7:0] left;
        logic rd_cfg;
        logic edge_cfg;
        logic rd;
        logic edge_b;
        logic cs_n;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [7:0] hq;
        logic [7:0] hoe_n;
        logic ack;
        logic [31:0] dat;
    } host_regs_t;

    host_regs_t s_reg;
    host_regs_t s_next;
    logic req;
    logic push_v;
    logic push_rdy;
    logic pop_v;
    logic pop;
    logic [7:0] pop_d;
    logic [7:0] remain;

    // Write data waits here; a full FIFO holds off the bus ack.
    host_port_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .in_data_i(dat_i[7:0]),
        .out_valid_o(pop_v),
        .out_ready_i(pop),
        .out_data_o(pop_d)
    );

    assign dat_o = s_reg.dat;
    assign ack_o = s_reg.ack;
    assign pins.mode_sel = s_reg.serial; // see RULE3
    assign pins.cs_n = s_reg.cs_n;
    assign pins.ale = s_reg.ale;
    assign pins.rd_n = s_reg.rd_n;
    assign pins.wr_n = s_reg.wr_n;
    assign pins.h_q = s_reg.hq;
    assign pins.h_oe_n = s_reg.hoe_n;

    // Bus slave, sequencer and pin decode.
    always_comb begin
        s_next = s_reg;
        pop = 1'b0;
        remain = s_reg.left;
        req = cyc_i && stb_i && !s_reg.ack;
        push_v = req && we_i && sel_i[0] && adr_i == `WB_TXDATA;
        s_next.ad1 = pins.ad;
        s_next.ad2 = s_reg.ad1;
        s_next.sp1 = serial_strap_i;
        s_next.sp2 = s_reg.sp1;
        // The strap is caught once, a few cycles after reset, and then held.
        if (s_reg.settle != `SETTLE_DONE) begin
            s_next.settle = s_reg.settle + 1'b1;
            s_next.serial = s_reg.sp2;
        end
        s_next.ack = req && (!push_v || push_rdy);
        if (s_next.ack && !we_i) begin
            case (adr_i)
                `WB_CTRL: s_next.dat = {29'h0, s_reg.edge_cfg, s_reg.rd_cfg, 1'b0};
                `WB_ADDR: s_next.dat = {24'h0, s_reg.addr_r};
                `WB_COUNT: s_next.dat = {24'h0, s_reg.count_r};
                `WB_RXDATA: s_next.dat = {24'h0, s_reg.rxdata};
                `WB_STATUS: s_next.dat = {28'h0, s_reg.serial, !push_rdy, !pop_v, s_reg.st != H_IDLE};
                default: s_next.dat = 32'h0000_0000;
            endcase
        end
        if (s_reg.tmr != 4'h0) begin
            s_next.tmr = s_reg.tmr - 1'b1;
        end
        if (s_next.ack && we_i && sel_i[0]) begin
            case (adr_i)
                `WB_ADDR: s_next.addr_r = dat_i[7:0];
                `WB_COUNT: s_next.count_r = dat_i[7:0];
                `WB_CTRL: begin
                    s_next.rd_cfg = dat_i[`CTRL_READ];
                    s_next.edge_cfg = dat_i[`CTRL_EDGE];
                    // A start while busy, before the strap settles or with no bytes is dropped.
                    if (dat_i[`CTRL_START] && s_reg.st == H_IDLE && s_reg.settle == `SETTLE_DONE
                        && s_reg.count_r != 8'h00) begin
                        s_next.cur = s_reg.addr_r;
                        s_next.left = s_reg.count_r;
                        s_next.rd = dat_i[`CTRL_READ];
                        s_next.edge_b = dat_i[`CTRL_EDGE];
                        s_next.tx = s_reg.addr_r;
                        s_next.bitc = 3'h0;
                        s_next.abyte = 1'b1;
                        s_next.tmr = 4'(PHASE - 1);
                        s_next.st = s_reg.serial ? H_CSS : H_ALE_HI;
                    end
                end
                default: ;
            endcase
        end

        case (s_reg.st)
            H_ALE_HI: if (s_reg.tmr == 4'h0) begin
                s_next.st = H_ALE_LO;
                s_next.tmr = 4'(PHASE - 1);
            end
            H_ALE_LO: if (s_reg.tmr == 4'h0 && (s_reg.rd || pop_v)) begin
                s_next.st = H_STB;
                s_next.tmr = 4'(PHASE - 1);
                if (!s_reg.rd) begin
                    s_next.tx = pop_d;
                    pop = 1'b1;
                end
            end
            H_STB: if (s_reg.tmr == 4'h0) begin
                s_next.st = H_REL;
                s_next.tmr = 4'(PHASE - 1);
                if (s_reg.rd) begin
                    s_next.rxdata = s_reg.ad2; // see RULE5
                end
            end
            H_REL: if (s_reg.tmr == 4'h0) begin
                s_next.left = s_reg.left - 1'b1;
                s_next.cur = s_reg.cur - 1'b1;
                s_next.tmr = 4'(PHASE - 1);
                s_next.st = (s_reg.left == 8'h01) ? H_IDLE : H_ALE_HI;
            end
            H_CSS: if (s_reg.tmr == 4'h0) begin
                s_next.st = H_LOW;
                s_next.tmr = 4'(HALF - 1);
            end
            H_LOW: if (s_reg.tmr == 4'h0) begin
                // Sampled just before the rising edge, after both output edges settle.
                s_next.rx = {s_reg.rx[6:0], s_reg.ad2[`SI_DO]}; // see RULE12
                s_next.st = H_HIGH;
                s_next.tmr = 4'(HALF - 1);
            end
            H_HIGH: if (s_reg.tmr == 4'h0) begin
                s_next.tx = {s_reg.tx[6:0], 1'b0};
                s_next.bitc = s_reg.bitc + 1'b1;
                s_next.tmr = 4'(HALF - 1);
                s_next.st = H_LOW;
                if (s_reg.bitc == 3'h7) begin
                    s_next.abyte = 1'b0;
                    if (!s_reg.abyte) begin
                        remain = s_reg.left - 1'b1;
                        if (s_reg.rd) begin
                            s_next.rxdata = s_reg.rx;
                        end
                    end
                    s_next.left = remain;
                    s_next.tmr = 4'(PHASE - 1);
                    s_next.st = (remain == 8'h00) ? H_END : H_LOAD; // see RULE9
                end
            end
            H_LOAD: if (s_reg.rd || pop_v) begin
                s_next.tx = s_reg.rd ? 8'h00 : pop_d;
                pop = !s_reg.rd;
                s_next.tmr = 4'(HALF - 1);
                s_next.st = H_LOW;
            end
            H_END: if (s_reg.tmr == 4'h0) begin
                s_next.st = H_IDLE; // see RULE8
            end
            default: ;
        endcase

        // Pin levels follow the next state so every pin is a register.
        s_next.cs_n = s_next.st == H_IDLE; // see RULE6, see RULE8
        s_next.ale = s_next.st == H_ALE_HI;
        s_next.rd_n = !(s_next.st == H_STB && s_next.rd);
        s_next.wr_n = !(s_next.st == H_STB && !s_next.rd);
        if (s_next.serial) begin
            s_next.hoe_n = `HOST_SI_OE; // see RULE7
            s_next.hq = 8'h00;
            s_next.hq[`SI_DIN] = s_next.tx[7];
            s_next.hq[`SI_CLK] = s_next.st == H_HIGH;
            s_next.hq[`SI_WN] = s_next.rd; // see RULE10
            s_next.hq[`SI_EDGE] = s_next.edge_b;
        end else if (s_next.st == H_ALE_HI || s_next.st == H_ALE_LO) begin
            s_next.hoe_n = `DRIVE_ALL; // see RULE4
            s_next.hq = s_next.cur;
        end else if ((s_next.st == H_STB || s_next.st == H_REL) && !s_next.rd) begin
            s_next.hoe_n = `DRIVE_ALL;
            s_next.hq = s_next.tx;
        end else begin
            s_next.hoe_n = `RELEASE_ALL;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.st <= H_IDLE;
            s_reg.cs_n <= 1'b1;
            s_reg.rd_n <= 1'b1;
            s_reg.wr_n <= 1'b1;
            s_reg.hoe_n <= `RELEASE_ALL;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : host_port_host
`default_nettype wire

//--- bench/host_port_sva.sv
// Concurrent checks on the pins that join the host end and the device end.
`timescale 1ns/10ps
`default_nettype none
module host_port_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control pins
    input wire logic mode_sel,
    input wire logic cs_n,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    // Bus drive enables
    input wire logic [7:0] h_oe_n,
    input wire logic [7:0] d_oe_n
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A parallel read begins when the read strobe falls inside a selected cycle.
    sequence rd_start;
        !mode_sel && !cs_n && $fell(rd_n);
    endsequence
    a_cs_release: assert property (cs_n [*5] |-> d_oe_n == 8'hFF)
        else $error("device drives while deselected");
    a_serial_pins: assert property (mode_sel [*4] |-> (d_oe_n | 8'h02) == 8'hFF)
        else $error("serial device drives a parallel line");
    a_par_width: assert property (!mode_sel && d_oe_n != 8'hFF |-> d_oe_n == 8'h00)
        else $error("parallel read drives part of the bus");
    a_par_select: assert property (!mode_sel && d_oe_n != 8'hFF |-> !cs_n)
        else $error("parallel drive without chip select");
    a_read_drive: assert property (rd_start |-> ##[1:6] d_oe_n == 8'h00)
        else $error("read strobe not answered on the bus");
    a_read_float: assert property (!mode_sel && $rose(rd_n) |-> ##[1:6] d_oe_n == 8'hFF)
        else $error("bus not released after read");
    a_strobe_select: assert property (!rd_n || !wr_n |-> !cs_n)
        else $error("strobe active without chip select");
    a_serial_idle: assert property (mode_sel |-> rd_n && wr_n && !ale)
        else $error("parallel strobe active in serial use");
    a_addr_hold: assert property ($fell(ale) |-> h_oe_n == 8'h00)
        else $error("address not held at latch strobe fall");
endmodule : host_port_sva
`default_nettype wire

//--- bench/dual_host_interface_tb.sv
// Self-checking bench: Wishbone-driven host end talking to the device end.
`timescale 1ns/10ps
`default_nettype none
module dual_host_interface_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic strap = 1'b0;
    logic ack;
    logic smode;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wpulse;
    logic [7:0] waddr;
    logic [7:0] wdata;
    int writes = 0;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    host_port_if pins_if ();
    host_port_host host_port_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .serial_strap_i(strap),
        .pins(pins_if.host));
    host_port_device host_port_device_inst (.clk_i(clk_i), .rst_i(rst_i), .pins(pins_if.dev), .status_i(8'h5A),
        .serial_mode_o(smode), .wr_pulse_o(wpulse), .wr_addr_o(waddr), .wr_data_o(wdata));
    host_port_sva host_port_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_sel(pins_if.mode_sel), .cs_n(pins_if.cs_n),
        .ale(pins_if.ale), .rd_n(pins_if.rd_n), .wr_n(pins_if.wr_n), .h_oe_n(pins_if.h_oe_n),
        .d_oe_n(pins_if.d_oe_n));
    // The clock runs at 25 MHz.
    always #20 clk_i = ~clk_i;
    // Cut a hang short; the slowest run here needs far fewer cycles.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        // Every register write, from either port, shows as one pulse.
        if (wpulse === 1'b1) begin
            writes <= writes + 1;
        end
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    // One classic Wishbone cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 32'h0);
        cmp(rdat, {24'h0, e});
    endtask : rd
    // Start a transfer and poll the busy bit until the host end is idle again.
    task automatic xfer(input logic [7:0] a, input logic [7:0] n, input logic [2:0] ctl);
        wb(1'b1, 8'h04, {24'h0, a});
        wb(1'b1, 8'h08, {24'h0, n});
        wb(1'b1, 8'h00, {29'h0, ctl});
        do wb(1'b0, 8'h14, 32'h0); while (rdat[0] !== 1'b0);
    endtask : xfer
    // The strap is only caught after reset, so each port mode needs its own reset.
    task automatic start(input logic s);
        strap <= s;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // The caught strap needs three more edges to reach the device's mode output.
        repeat (8) @(posedge clk_i);
    endtask : start
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // Parallel use: fill the buffer, drain it into 0F down to 00, then read back.
    initial begin
        start(1'b0);
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, 8'h0C, 32'(i));
        end
        rd(8'h14, 8'h04);
        xfer(8'h0F, 8'h10, 3'h1);
        rd(8'h14, 8'h02);
        xfer(8'h0F, 8'h01, 3'h3);
        rd(8'h10, 8'h00);
        xfer(8'h06, 8'h02, 3'h3);
        rd(8'h10, 8'h0A);
        xfer(8'hFF, 8'h01, 3'h3);
        rd(8'h10, 8'h5A);
        rd(8'h18, 8'h00);
        // Serial use: set auto-decrement, write two bytes, read back in both output timings.
        start(1'b1);
        cmp(32'(smode), 32'h1);
        wb(1'b1, 8'h0C, 32'h02);
        xfer(8'h00, 8'h01, 3'h1);
        wb(1'b1, 8'h0C, 32'h11);
        wb(1'b1, 8'h0C, 32'h22);
        xfer(8'h09, 8'h02, 3'h1);
        xfer(8'h09, 8'h02, 3'h3);
        rd(8'h10, 8'h22);
        xfer(8'h09, 8'h01, 3'h7);
        rd(8'h10, 8'h11);
        xfer(8'h00, 8'h01, 3'h3);
        rd(8'h10, 8'h02);
        rd(8'h14, 8'h0A);
        // Sixteen parallel and three serial writes; the last one went to 08.
        cmp(32'(writes), 32'h13);
        cmp({16'h0, waddr, wdata}, 32'h0000_0822);
        conclude();
    end
endmodule : dual_host_interface_tb
`default_nettype wire
